// File: common/hbm_pkg.sv
// package for the host bus port: constants, states and carriers
// assumes a single bus clock shared by master and slave logic
package hbm_pkg;
  // ****************************************
  // widths and timing
  // ****************************************
  localparam int          ADDR_W      = 32;
  localparam int          DATA_W      = 32;
  localparam int          BEAT_W      = 3;
  localparam int          WAIT_STATES = 3;         // mandatory slave wait clocks
  localparam logic [2:0]  LINE_BEATS  = 3'h4;      // beats in one cache line
  localparam logic [31:0] BEAT_BYTES  = 32'h4;     // address step per beat
  // ****************************************
  // encodings driven on the control lines
  // ****************************************
  localparam logic [1:0]  SIZE_LINE   = 2'h3;
  localparam logic [1:0]  SIZE_WORD   = 2'h0;
  localparam logic [1:0]  TT_NORMAL   = 2'h0;
  localparam logic [2:0]  FC_DATA     = 3'h5;
  // ****************************************
  // states, gray coded along the usual path except the step back to idle
  // ****************************************
  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_CTRL = 3'h1, M_TIP = 3'h3,
    M_ADDR = 3'h2, M_DATA = 3'h6, M_DONE = 3'h7
  } hbm_mstate_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_SEL = 3'h1, S_WAIT = 3'h3,
    S_RESP = 3'h2, S_END = 3'h6
  } hbm_sstate_t;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic              write;
    logic [1:0]        snoop;
    logic [ADDR_W-1:0] addr;
    logic [BEAT_W-1:0] beats;
  } hbm_cmd_t;
  typedef struct packed {
    logic        write;
    logic [4:0]  addr;
    logic [3:0]  byte_enables;
    logic [DATA_W-1:0] data;
  } hbm_sreq_t;
endpackage

// File: rtl/hbm_fifo.sv
// synchronous valid/ready fifo in flip-flops
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module hbm_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input  wire logic         mclk_in,
  input  wire logic         reset_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);
  initial begin
    if (D < 2 || (1 << AW) != D) $error("fifo depth must be a power of two");
  end
  logic [W-1:0] mem_reg [D];
  logic [AW:0]  wr_ptr_reg;
  logic [AW:0]  rd_ptr_reg;
  logic         push;
  logic         pop;
  // full and empty from pointer wrap bit
  assign in_ready_out  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
  assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;
  // storage
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end
  // pointers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule // hbm_fifo
`default_nettype wire

// File: rtl/hbm_host_port.sv
// host bus port: multiplexed master cycles and slave register cycles
// assumes all pins synchronous to mclk_in; two-way pins resolved outside
// Notes on behaviour
// - once owning the bus, drive direction, snoop, function and type lines first
// - then assert transfer in progress, then start strobe with address and size
// - mux read: drop start strobe and float address so responder drives data
// - burst inhibit clear means line burst; asserted means single transfers
// - error acknowledge together with acknowledge retries the cycle
// - error acknowledge alone ends the access with a bus fault
// - clean acknowledge with beats left returns to the address phase
// - mux write: data off in address phase, then float address, drive data
// - end of mux write drops control lines and stops driving data
// - after last acknowledge drop master and bus grant acknowledge
// - chip select sampled on a rising edge following address status
// - burst inhibit asserted throughout every slave access
// - exactly three wait clocks per slave access; read data driven from the second wait on
// - after the waits assert ready out when no error found
// - on error assert only error acknowledge; cycle ends next edge
// - the asserted response is deasserted afterwards
// - without error wait for ready in before ending the slave cycle
// - slave read ends with data drivers released
`timescale 1ns/1ps
`default_nettype none
module hbm_host_port #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                  mclk_in,
  input  wire logic                  reset_in,
  // user command side
  input  wire logic                  cmd_valid_in,
  output logic                       cmd_ready_out,
  input  wire hbm_pkg::hbm_cmd_t     cmd_in,
  input  wire logic                  burst_disable_in,
  input  wire logic                  wr_valid_in,
  output logic                       wr_ready_out,
  input  wire logic [31:0]           wr_data_in,
  output logic                       rd_valid_out,
  input  wire logic                  rd_ready_in,
  output logic [31:0]                rd_data_out,
  output logic                       done_out,
  output logic                       bus_fault_out,
  // master pins
  input  wire logic                  bus_granted_in,
  input  wire logic [31:0]           ad_in,
  output logic [31:0]                ad_out,
  output logic                       ad_oe_out,
  output logic                       ctrl_oe_out,
  output logic                       rw_out,
  output logic [1:0]                 snoop_ctl_out,
  output logic [2:0]                 func_ctl_out,
  output logic [1:0]                 xfer_type_out,
  output logic [1:0]                 size_out,
  output logic                       tip_n_out,
  output logic                       ts_n_out,
  output logic                       master_n_out,
  output logic                       grant_ack_n_out,
  input  wire logic                  ta_n_in,
  input  wire logic                  error_acknowledge_n_in,
  output logic                       error_acknowledge_n_out,
  output logic                       error_acknowledge_oe_out,
  input  wire logic                  burst_inhibit_n_in,
  output logic                       burst_inhibit_n_out,
  output logic                       burst_inhibit_oe_out,
  // slave pins
  input  wire logic                  address_strobe_n_in,
  input  wire logic                  chip_select_n_in,
  input  wire logic                  slave_write_in,
  input  wire logic [4:0]            slave_addr_in,
  input  wire logic [3:0]            byte_enables_in,
  input  wire logic [31:0]           slave_data_in,
  output logic [31:0]                slave_data_out,
  output logic                       slave_data_oe_out,
  output logic                       slave_ready_out_n_out,
  input  wire logic                  system_ready_in_n_in,
  // slave user side
  output logic                       sreq_valid_out,
  output hbm_pkg::hbm_sreq_t         sreq_out,
  input  wire logic [31:0]           srd_data_in,
  input  wire logic                  serr_in
);
  // ****************************************
  // master sequencer
  // ****************************************
  initial begin
    if (FIFO_DEPTH < 2) $error("fifo depth too small");
  end
  hbm_pkg::hbm_mstate_t m_state_reg;
  hbm_pkg::hbm_mstate_t m_state_next;
  hbm_pkg::hbm_cmd_t    cmd_reg;
  logic [2:0]           beat_reg;
  logic                 burst_reg;
  logic [31:0]          wdata_reg;
  logic                 fifo_ready;
  logic                 ta;
  logic                 tea;
  logic                 can_issue;
  logic                 last_beat;
  logic                 beat_ok;

  // address of the current beat
  function automatic logic [31:0] beat_addr(input logic [31:0] base, input logic [2:0] n);
    beat_addr = base + (32'(n) * hbm_pkg::BEAT_BYTES);
  endfunction

  assign ta        = !ta_n_in;
  assign tea       = !error_acknowledge_n_in;
  assign beat_ok   = (m_state_reg == hbm_pkg::M_DATA) && ta && !tea;
  assign last_beat = (beat_reg + 3'h1) == cmd_reg.beats;
  // reads stall on a full buffer, writes on missing data
  assign can_issue = cmd_reg.write ? wr_valid_in : fifo_ready;
  assign cmd_ready_out = (m_state_reg == hbm_pkg::M_IDLE) && bus_granted_in;
  assign wr_ready_out  = cmd_reg.write && can_issue &&
                         (m_state_next == hbm_pkg::M_ADDR) && !(ta && tea);

  // next state of the master cycle
  always_comb begin
    m_state_next = m_state_reg;
    case (m_state_reg)
      hbm_pkg::M_IDLE: begin
        if (cmd_valid_in && cmd_ready_out) m_state_next = hbm_pkg::M_CTRL;
      end
      hbm_pkg::M_CTRL: m_state_next = hbm_pkg::M_TIP;
      hbm_pkg::M_TIP: begin
        if (can_issue) m_state_next = hbm_pkg::M_ADDR;
      end
      hbm_pkg::M_ADDR: m_state_next = hbm_pkg::M_DATA;
      hbm_pkg::M_DATA: begin
        if (ta && tea) begin
          m_state_next = hbm_pkg::M_ADDR;
        end else if (tea) begin
          m_state_next = hbm_pkg::M_DONE;
        end else if (ta && last_beat) begin
          m_state_next = hbm_pkg::M_DONE;
        end else if (ta) begin
          m_state_next = can_issue ? hbm_pkg::M_ADDR : hbm_pkg::M_TIP;
        end
      end
      hbm_pkg::M_DONE: m_state_next = hbm_pkg::M_IDLE;
      default: m_state_next = hbm_pkg::M_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk_in) begin
    if (reset_in) m_state_reg <= hbm_pkg::M_IDLE;
    else          m_state_reg <= m_state_next;
  end

  // command, beat count and burst mode
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cmd_reg   <= '0;
      beat_reg  <= '0;
      burst_reg <= 1'b0;
    end else if (cmd_valid_in && cmd_ready_out) begin
      cmd_reg   <= cmd_in;
      beat_reg  <= '0;
      burst_reg <= !burst_disable_in && (cmd_in.beats == hbm_pkg::LINE_BEATS);
    end else if (beat_ok) begin
      beat_reg <= beat_reg + 3'h1;
      if (!burst_inhibit_n_in) burst_reg <= 1'b0;
    end
  end

  // write data held across retries
  always_ff @(posedge mclk_in) begin
    if (reset_in)          wdata_reg <= '0;
    else if (wr_ready_out) wdata_reg <= wr_data_in;
  end

  // registered master pins, taken from the next state
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ctrl_oe_out     <= 1'b0;
      rw_out          <= 1'b1;
      snoop_ctl_out   <= '0;
      func_ctl_out    <= '0;
      xfer_type_out   <= '0;
      size_out        <= '0;
      tip_n_out       <= 1'b1;
      ts_n_out        <= 1'b1;
      master_n_out    <= 1'b1;
      grant_ack_n_out <= 1'b1;
      ad_out          <= '0;
      ad_oe_out       <= 1'b0;
    end else begin
      ctrl_oe_out     <= m_state_next inside {hbm_pkg::M_CTRL, hbm_pkg::M_TIP,
                         hbm_pkg::M_ADDR, hbm_pkg::M_DATA};
      master_n_out    <= m_state_next inside {hbm_pkg::M_IDLE, hbm_pkg::M_DONE};
      grant_ack_n_out <= m_state_next inside {hbm_pkg::M_IDLE, hbm_pkg::M_DONE};
      tip_n_out       <= !(m_state_next inside {hbm_pkg::M_TIP, hbm_pkg::M_ADDR,
                         hbm_pkg::M_DATA});
      ts_n_out        <= m_state_next != hbm_pkg::M_ADDR;
      if (cmd_valid_in && cmd_ready_out) begin
        rw_out        <= !cmd_in.write;
        snoop_ctl_out <= cmd_in.snoop;
        func_ctl_out  <= hbm_pkg::FC_DATA;
        xfer_type_out <= hbm_pkg::TT_NORMAL;
      end
      size_out <= (burst_reg && !(beat_ok && !burst_inhibit_n_in)) ?
                  hbm_pkg::SIZE_LINE : hbm_pkg::SIZE_WORD;
      if (m_state_next == hbm_pkg::M_ADDR) begin
        ad_out <= beat_addr(cmd_reg.addr, beat_reg + 3'(beat_ok));
      end else begin
        ad_out <= wr_ready_out ? wr_data_in : wdata_reg;
      end
      // address phase drives address; write data phase drives data
      ad_oe_out <= (m_state_next == hbm_pkg::M_ADDR) ||
                   (m_state_next == hbm_pkg::M_DATA && cmd_reg.write);
    end
  end

  // end of command and fault reporting
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      done_out      <= 1'b0;
      bus_fault_out <= 1'b0;
    end else begin
      done_out      <= m_state_next == hbm_pkg::M_DONE;
      bus_fault_out <= (m_state_reg == hbm_pkg::M_DATA) && tea && !ta;
    end
  end

  // read data buffer; full buffer stalls the next start
  hbm_fifo #(
    .W (32),
    .D (FIFO_DEPTH)
  ) u_rd_fifo (
    .mclk_in       (mclk_in),
    .reset_in      (reset_in),
    .in_valid_in   (beat_ok && !cmd_reg.write),
    .in_ready_out  (fifo_ready),
    .in_data_in    (ad_in),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (rd_data_out)
  );

  // ****************************************
  // slave sequencer
  // ****************************************
  hbm_pkg::hbm_sstate_t s_state_reg;
  hbm_pkg::hbm_sstate_t s_state_next;
  logic [1:0]           s_cnt_reg;
  logic                 s_err_reg;
  logic                 s_wait_end;

  assign s_wait_end = s_cnt_reg == 2'(hbm_pkg::WAIT_STATES - 1);

  // next state of the slave cycle
  always_comb begin
    s_state_next = s_state_reg;
    case (s_state_reg)
      hbm_pkg::S_IDLE: begin
        if (!address_strobe_n_in) s_state_next = hbm_pkg::S_SEL;
      end
      hbm_pkg::S_SEL: begin
        s_state_next = chip_select_n_in ? hbm_pkg::S_IDLE : hbm_pkg::S_WAIT;
      end
      hbm_pkg::S_WAIT: begin
        if (s_wait_end) s_state_next = hbm_pkg::S_RESP;
      end
      hbm_pkg::S_RESP: begin
        if (s_err_reg || !system_ready_in_n_in) s_state_next = hbm_pkg::S_IDLE;
        else s_state_next = hbm_pkg::S_END;
      end
      hbm_pkg::S_END: begin
        if (!system_ready_in_n_in) s_state_next = hbm_pkg::S_IDLE;
      end
      default: s_state_next = hbm_pkg::S_IDLE;
    endcase
  end

  // state, wait count and captured request
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s_state_reg    <= hbm_pkg::S_IDLE;
      s_cnt_reg      <= '0;
      s_err_reg      <= 1'b0;
      sreq_out       <= '0;
      sreq_valid_out <= 1'b0;
    end else begin
      s_state_reg    <= s_state_next;
      s_cnt_reg      <= (s_state_reg == hbm_pkg::S_WAIT) ? s_cnt_reg + 2'h1 : 2'h0;
      sreq_valid_out <= (s_state_reg == hbm_pkg::S_WAIT) && s_wait_end;
      if (s_state_reg == hbm_pkg::S_SEL) begin
        sreq_out.write        <= slave_write_in;
        sreq_out.addr         <= slave_addr_in;
        sreq_out.byte_enables <= byte_enables_in;
      end
      if (s_state_reg == hbm_pkg::S_WAIT && s_wait_end) begin
        sreq_out.data <= slave_data_in;
        s_err_reg     <= serr_in;
      end
    end
  end

  // registered slave pins
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      burst_inhibit_n_out      <= 1'b1;
      burst_inhibit_oe_out     <= 1'b0;
      slave_ready_out_n_out    <= 1'b1;
      error_acknowledge_n_out  <= 1'b1;
      error_acknowledge_oe_out <= 1'b0;
      slave_data_oe_out        <= 1'b0;
      slave_data_out           <= '0;
    end else begin
      burst_inhibit_n_out  <= s_state_next inside {hbm_pkg::S_IDLE, hbm_pkg::S_SEL};
      burst_inhibit_oe_out <= !(s_state_next inside {hbm_pkg::S_IDLE, hbm_pkg::S_SEL});
      slave_ready_out_n_out <= !(s_state_next == hbm_pkg::S_RESP && !serr_in &&
                               s_state_reg == hbm_pkg::S_WAIT);
      error_acknowledge_n_out <= !(s_state_next == hbm_pkg::S_RESP && serr_in &&
                                 s_state_reg == hbm_pkg::S_WAIT);
      error_acknowledge_oe_out <= s_state_next == hbm_pkg::S_RESP &&
                                  s_state_reg == hbm_pkg::S_WAIT && serr_in;
      // read data driven from the second wait clock until the cycle ends
      slave_data_oe_out <= !sreq_out.write && !(s_state_next inside
                           {hbm_pkg::S_IDLE, hbm_pkg::S_SEL}) &&
                           s_state_reg != hbm_pkg::S_SEL;
      slave_data_out    <= srd_data_in;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  ctrl_before_tip_a: assert property ($fell(tip_n_out) |-> $past(ctrl_oe_out))
    else $error("tip asserted before control lines");
  ts_under_tip_a: assert property (!ts_n_out |-> !tip_n_out && ad_oe_out)
    else $error("start strobe without tip or address");
  read_float_a: assert property (!ts_n_out && rw_out |=> !ad_oe_out)
    else $error("address not released in read");
  retry_addr_a: assert property (m_state_reg == hbm_pkg::M_DATA && ta && tea
                  |=> !ts_n_out && $stable(beat_reg))
    else $error("retry did not reissue the beat");
  fault_end_a: assert property (m_state_reg == hbm_pkg::M_DATA && tea && !ta
                  |=> bus_fault_out ##1 master_n_out)
    else $error("fault did not end the access");
  next_beat_a: assert property (beat_ok && !last_beat && can_issue |=> !ts_n_out)
    else $error("next beat not started");
  write_phase_a: assert property (!ts_n_out && !rw_out |=> ad_oe_out ##0 ts_n_out)
    else $error("write data not driven after start");
  release_bus_a: assert property (beat_ok && last_beat
                  |=> master_n_out && grant_ack_n_out && !ctrl_oe_out && !ad_oe_out)
    else $error("bus not released after last beat");
  tbi_slave_a: assert property (s_state_reg inside {hbm_pkg::S_WAIT, hbm_pkg::S_RESP,
                  hbm_pkg::S_END} |-> !burst_inhibit_n_out)
    else $error("burst inhibit missing in slave access");
  wait_three_a: assert property (s_state_reg == hbm_pkg::S_SEL && !chip_select_n_in
                  |=> (slave_ready_out_n_out && error_acknowledge_n_out) [*3]
                  ##1 !(slave_ready_out_n_out && error_acknowledge_n_out))
    else $error("response not after three waits");
  resp_once_a: assert property (!slave_ready_out_n_out || !error_acknowledge_n_out
                  |=> slave_ready_out_n_out && error_acknowledge_n_out)
    else $error("response held too long");
  err_only_a: assert property (!error_acknowledge_n_out
                  |-> slave_ready_out_n_out ##1 s_state_reg == hbm_pkg::S_IDLE)
    else $error("error response not alone or cycle not ended");
  hold_ready_a: assert property (s_state_reg == hbm_pkg::S_END && system_ready_in_n_in
                  |=> s_state_reg == hbm_pkg::S_END)
    else $error("slave cycle ended without ready in");
  drop_data_a: assert property (s_state_reg == hbm_pkg::S_IDLE |-> !slave_data_oe_out)
    else $error("slave data still driven");

  read_cov_c:  cover property (beat_ok && last_beat && !cmd_reg.write);
  retry_cov_c: cover property (m_state_reg == hbm_pkg::M_DATA && ta && tea);
  slave_cov_c: cover property (s_state_reg == hbm_pkg::S_END && !system_ready_in_n_in);
endmodule // hbm_host_port
`default_nettype wire

// File: dv/hbm_bus_resp.sv
// responder model for the multiplexed master bus of the host port
// assumes one clock, synchronous active high reset, pull-ups on acks
`timescale 1ns/1ps
`default_nettype none
module hbm_bus_resp (
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        ts_n_in,
  input  wire logic        ad_oe_in,
  input  wire logic [31:0] ad_drv_in,
  input  wire logic [1:0]  err_mode_in,
  output logic             ta_n_out,
  output logic             tea_n_out,
  output logic             tbi_n_out,
  output logic [31:0]      ad_out
);
  // ****************************************
  // beat capture and answer
  // ****************************************
  logic        resp_reg;
  logic        retried_reg;
  logic [31:0] drv_reg;
  // answer one cycle after each start strobe
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      resp_reg    <= 1'b0;
      retried_reg <= 1'b0;
      drv_reg     <= 32'h0;
    end else begin
      resp_reg <= !ts_n_in;
      if (!ts_n_in) drv_reg <= ad_drv_in ^ 32'h5A5A5A5A;
      if (resp_reg && err_mode_in == 2'h1) retried_reg <= 1'b1;
    end
  end
  // mode 1 asks one retry, mode 2 a fault, mode 3 burst inhibit
  assign ta_n_out  = !(resp_reg && err_mode_in != 2'h2);
  assign tea_n_out = !(resp_reg && (err_mode_in == 2'h2 || (err_mode_in == 2'h1 && !retried_reg)));
  assign tbi_n_out = !(resp_reg && err_mode_in == 2'h3);
  // shared pins: device drive wins, idle shows inverse of last data
  assign ad_out = ad_oe_in ? ad_drv_in : (resp_reg ? drv_reg : ~drv_reg);
endmodule // hbm_bus_resp
`default_nettype wire

// File: dv/test_hbm_host_port.sv
// bench for the host port: master cycles against the responder, slave cycles by hand
// assumes the responder model and the design are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_hbm_host_port;
  // ****************************************
  // signals
  // ****************************************
  logic mclk_in, reset_in, cmd_valid_in, cmd_ready_out, burst_disable_in, wr_valid_in;
  logic wr_ready_out, rd_valid_out, rd_ready_in, done_out, bus_fault_out, bus_granted_in;
  logic ad_oe_out, ctrl_oe_out, rw_out, tip_n_out, ts_n_out, master_n_out, grant_ack_n_out;
  logic ta_n_in, error_acknowledge_n_in, error_acknowledge_n_out, error_acknowledge_oe_out;
  logic burst_inhibit_n_in, burst_inhibit_n_out, burst_inhibit_oe_out, address_strobe_n_in;
  logic chip_select_n_in, slave_write_in, slave_data_oe_out, slave_ready_out_n_out;
  logic system_ready_in_n_in, sreq_valid_out, serr_in, m_tea_n, m_tbi_n;
  logic [31:0] wr_data_in, rd_data_out, ad_in, ad_out, slave_data_in;
  logic [31:0] slave_data_out, srd_data_in;
  logic [4:0]  slave_addr_in;
  logic [3:0]  byte_enables_in;
  logic [2:0]  func_ctl_out;
  logic [1:0]  snoop_ctl_out, xfer_type_out, size_out, err_mode;
  hbm_pkg::hbm_cmd_t  cmd_in;
  hbm_pkg::hbm_sreq_t sreq_out;
  int n_fail, n_checks;
  // clock and shared open-drain lines
  always #5 mclk_in = ~mclk_in;
  assign error_acknowledge_n_in = error_acknowledge_oe_out ? error_acknowledge_n_out : m_tea_n;
  assign burst_inhibit_n_in = burst_inhibit_oe_out ? burst_inhibit_n_out : m_tbi_n;
  hbm_host_port #(.FIFO_DEPTH(16)) hbm_host_port_inst (.mclk_in, .reset_in, .cmd_valid_in,
    .cmd_ready_out, .cmd_in, .burst_disable_in, .wr_valid_in, .wr_ready_out, .wr_data_in,
    .rd_valid_out, .rd_ready_in, .rd_data_out, .done_out, .bus_fault_out, .bus_granted_in,
    .ad_in, .ad_out, .ad_oe_out, .ctrl_oe_out, .rw_out, .snoop_ctl_out, .func_ctl_out,
    .xfer_type_out, .size_out, .tip_n_out, .ts_n_out, .master_n_out, .grant_ack_n_out,
    .ta_n_in, .error_acknowledge_n_in, .error_acknowledge_n_out, .error_acknowledge_oe_out,
    .burst_inhibit_n_in, .burst_inhibit_n_out, .burst_inhibit_oe_out, .address_strobe_n_in,
    .chip_select_n_in, .slave_write_in, .slave_addr_in, .byte_enables_in, .slave_data_in,
    .slave_data_out, .slave_data_oe_out, .slave_ready_out_n_out, .system_ready_in_n_in,
    .sreq_valid_out, .sreq_out, .srd_data_in, .serr_in);
  hbm_bus_resp hbm_bus_resp_inst (.mclk_in, .reset_in, .ts_n_in(ts_n_out),
    .ad_oe_in(ad_oe_out), .ad_drv_in(ad_out), .err_mode_in(err_mode), .ta_n_out(ta_n_in),
    .tea_n_out(m_tea_n), .tbi_n_out(m_tbi_n), .ad_out(ad_in));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one master command, watched beat by beat
  task automatic mcyc(input logic wr, input logic [2:0] nb, input logic [31:0] a,
                      input logic [1:0] sz, input int ets, input int eflt);
    int i, nts, acks, pops, flt;
    logic [1:0] esz;
    nts = 0; acks = 0; pops = 0; flt = 0; esz = sz;
    cmd_in = '{write: wr, snoop: 2'h1, addr: a, beats: nb};
    wr_valid_in = wr;
    wr_data_in = ~a;
    cmd_valid_in = 1'b1;
    for (i = 0; i < 20 && cmd_ready_out !== 1'b1; i++) @(negedge mclk_in);
    if (i == 20) begin
      n_fail++;
      stop_test();
    end
    @(negedge mclk_in);
    cmd_valid_in = 1'b0;
    chk({ctrl_oe_out, tip_n_out, rw_out, snoop_ctl_out, func_ctl_out, xfer_type_out},
        {2'h3, !wr, 2'h1, hbm_pkg::FC_DATA, hbm_pkg::TT_NORMAL});
    for (i = 0; i < 100; i++) begin
      if (ts_n_out === 1'b0) begin
        nts++;
        chk({tip_n_out, ad_oe_out, size_out, ad_out}, {2'h1, esz, a + acks * 4});
        if (wr) wr_data_in = ~(a + acks * 4 + 4);
      end
      if (ta_n_in === 1'b0) begin
        chk(ad_oe_out, wr);
        if (wr) chk(ad_out, {~(a + acks * 4)});
        if (burst_inhibit_n_in === 1'b0) esz = hbm_pkg::SIZE_WORD;
        acks += error_acknowledge_n_in;
      end
      if (rd_valid_out === 1'b1) begin
        chk(rd_data_out, (a + pops * 4) ^ 32'h5A5A5A5A);
        pops++;
      end
      if (bus_fault_out === 1'b1) flt++;
      if (done_out === 1'b1) break;
      @(negedge mclk_in);
    end
    if (i == 100) begin
      n_fail++;
      stop_test();
    end
    chk({master_n_out, grant_ack_n_out, ctrl_oe_out, ad_oe_out}, 4'hC);
    chk(nts, ets);
    chk(flt, eflt);
    chk(pops, (wr || eflt != 0) ? 0 : nb);
    wr_valid_in = 1'b0;
    @(negedge mclk_in);
  endtask
  // one slave access; ready in held back one cycle
  task automatic scyc(input logic wr, input logic err);
    int i;
    address_strobe_n_in = 0; chip_select_n_in = 0; slave_write_in = wr; serr_in = err;
    slave_addr_in = 5'h0C; slave_data_in = 32'h1234ABCD; srd_data_in = 32'hBEEF0001;
    @(negedge mclk_in);
    address_strobe_n_in = 1'b1;
    for (i = 1; i < 12 && (slave_ready_out_n_out & error_acknowledge_n_out) === 1'b1; i++)
      @(negedge mclk_in);
    chk(i, 5);
    if (i == 12) stop_test();
    chk({burst_inhibit_oe_out, burst_inhibit_n_out, slave_ready_out_n_out,
         error_acknowledge_n_out, error_acknowledge_oe_out}, {2'h2, err, !err, err});
    chk({sreq_valid_out, sreq_out.write, sreq_out.addr, sreq_out.byte_enables},
        {1'b1, wr, 5'h0C, 4'hF});
    if (wr) chk(sreq_out.data, 32'h1234ABCD);
    else chk({slave_data_oe_out, slave_data_out}, {1'b1, 32'hBEEF0001});
    @(negedge mclk_in);
    chk({slave_ready_out_n_out, error_acknowledge_n_out, burst_inhibit_oe_out}, {2'h3, !err});
    system_ready_in_n_in = err;
    @(negedge mclk_in);
    system_ready_in_n_in = 1'b1;
    chip_select_n_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    chk({slave_data_oe_out, burst_inhibit_oe_out}, 2'h0);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    mclk_in = 0; reset_in = 1; cmd_valid_in = 0; burst_disable_in = 0; wr_valid_in = 0;
    wr_data_in = 0; rd_ready_in = 1; bus_granted_in = 1; address_strobe_n_in = 1;
    chip_select_n_in = 1; slave_write_in = 0; slave_addr_in = 0; byte_enables_in = 4'hF;
    slave_data_in = 0; system_ready_in_n_in = 1; srd_data_in = 0; serr_in = 0;
    err_mode = 0; cmd_in = '0; n_fail = 0; n_checks = 0;
    repeat (10) @(negedge mclk_in);
    reset_in = 0;
    mcyc(0, 3'h1, 32'h00001000, hbm_pkg::SIZE_WORD, 1, 0);
    mcyc(1, 3'h4, 32'h00002000, hbm_pkg::SIZE_LINE, 4, 0);
    burst_disable_in = 1;
    mcyc(0, 3'h4, 32'h00003000, hbm_pkg::SIZE_WORD, 4, 0);
    burst_disable_in = 0;
    err_mode = 2'h3;
    mcyc(0, 3'h4, 32'h00006000, hbm_pkg::SIZE_LINE, 4, 0);
    err_mode = 2'h1;
    mcyc(0, 3'h1, 32'h00004000, hbm_pkg::SIZE_WORD, 2, 0);
    err_mode = 2'h2;
    mcyc(1, 3'h1, 32'h00005000, hbm_pkg::SIZE_WORD, 1, 1);
    err_mode = 2'h0;
    scyc(0, 0);
    scyc(1, 0);
    scyc(0, 1);
    stop_test();
  end
endmodule // test_hbm_host_port
`default_nettype wire
